/* pkg/hsc_pkg.sv */
`default_nettype none
package hsc_pkg;
  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IDLE_RUN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WUP_LSB = 2;
  localparam int CTRL_RELCLK_BIT = 4;
  localparam int CTRL_DRVSEL_BIT = 5;
  localparam int CTRL_DRVEN_BIT = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [6:0] IDLE_RUN_RESET = 7'h00;
  localparam logic [2:0] MASK_RESET = 3'h7;
  // Halt mode select codes
  localparam logic [1:0] MODE_RESERVED = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_OSC_ONLY = 2'h2;
  localparam logic [1:0] MODE_CPU_ONLY = 2'h3;
  // Warm-up exponents
  localparam int WUP_EXP_01 = 8;
  localparam int WUP_EXP_10 = 14;
  localparam int WUP_EXP_11 = 16;
  // Entry window of roughly 5 cpu clocks
  localparam int ENTRY_CYCLES = 5;
  localparam int NMI_LEVEL = 7;
  // Wake sources
  localparam int NSRC = 12;
  localparam int SRC_NMI = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_KEY = 2;
  localparam int SRC_ALM = 3;
  localparam int SRC_RTC = 4;
  localparam int SRC_WDT = 5;
  localparam int SRC_TMR = 6;
  localparam int SRC_SER = 7;
  localparam int SRC_ADC = 8;
  localparam int SRC_SBI = 9;
  localparam int SRC_LCD = 10;
  localparam int SRC_SBUS = 11;
  localparam logic [NSRC-1:0] OSC_WAKE = 12'h01F;
  localparam logic [NSRC-1:0] STOP_WAKE = 12'h007;
  localparam logic [NSRC-1:0] BELOW_WAKE = 12'h01E;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_CPU_HALT = 3'b001,
    ST_OSC_HALT = 3'b010,
    ST_STOP = 3'b011,
    ST_WARM = 3'b100
  } hsc_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] wup;
    logic rel_clk;
    logic drv_sel;
    logic drv_en;
  } hsc_cfg_t;

  typedef struct packed {
    logic cpu_stop;
    logic sys_clk_stop;
    logic osc_stop;
    logic rtc_stop;
    logic intc_stop;
    logic pins_hold;
    logic pins_off;
    logic clk_sel_low;
  } hsc_gate_t;
endpackage : hsc_pkg
`default_nettype wire

/* hw/hsc_warmup.sv */
`timescale 1ns/1ps
`default_nettype none
module hsc_warmup #(
  parameter int CW = 17
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic [1:0] sel,
  input wire logic osc_tick,
  output logic done
);
  if (CW < hsc_pkg::WUP_EXP_11 + 1) begin : g_cw_check
    $error("hsc_warmup: CW too small");
  end

  function automatic logic [CW-1:0] limit(input logic [1:0] s);
    case (s)
      2'h1: limit = CW'(1) << hsc_pkg::WUP_EXP_01;
      2'h2: limit = CW'(1) << hsc_pkg::WUP_EXP_10;
      default: limit = CW'(1) << hsc_pkg::WUP_EXP_11;
    endcase
  endfunction : limit

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (start) begin
      cnt_nxt = '0;
      run_nxt = 1'b1;
    end else if (run_r && osc_tick) begin
      cnt_nxt = cnt_r + CW'(1);
      if (cnt_nxt == limit(sel)) run_nxt = 1'b0; // [RULE16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  assign done = run_r && !run_nxt;
endmodule : hsc_warmup
`default_nettype wire

/* hw/hsc_apb_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module hsc_apb_regs (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register contents
  output hsc_pkg::hsc_cfg_t cfg,
  output logic [6:0] idle_run,
  output logic [2:0] mask_level,
  input wire logic [31:0] status
);
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [6:0] idle_r, idle_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic err_r, err_nxt;
  logic acc;

  assign acc = psel && penable;

  always_comb begin
    ctrl_nxt = ctrl_r;
    idle_nxt = idle_r;
    mask_nxt = mask_r;
    rd_nxt = rd_r;
    err_nxt = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        hsc_pkg::ADDR_CTRL: rd_nxt = ctrl_r;
        hsc_pkg::ADDR_IDLE_RUN: rd_nxt = {25'h0, idle_r};
        hsc_pkg::ADDR_STATUS: rd_nxt = status;
        hsc_pkg::ADDR_MASK: rd_nxt = {29'h0, mask_r};
        default: begin
          rd_nxt = 32'h0000_0000;
          err_nxt = 1'b1;
        end
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        hsc_pkg::ADDR_CTRL: ctrl_nxt = {25'h0, pwdata[6:0]};
        hsc_pkg::ADDR_IDLE_RUN: idle_nxt = pwdata[6:0];
        hsc_pkg::ADDR_MASK: mask_nxt = pwdata[2:0];
        default: ;
      endcase
    end
    if (acc) err_nxt = err_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= hsc_pkg::CTRL_RESET;
      idle_r <= hsc_pkg::IDLE_RUN_RESET;
      mask_r <= hsc_pkg::MASK_RESET;
      rd_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      idle_r <= idle_nxt;
      mask_r <= mask_nxt;
      rd_r <= rd_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata = rd_r;
  assign pready = 1'b1;
  assign pslverr = err_r;
  assign cfg.mode = ctrl_r[hsc_pkg::CTRL_MODE_LSB +: 2];
  assign cfg.wup = ctrl_r[hsc_pkg::CTRL_WUP_LSB +: 2];
  assign cfg.rel_clk = ctrl_r[hsc_pkg::CTRL_RELCLK_BIT];
  assign cfg.drv_sel = ctrl_r[hsc_pkg::CTRL_DRVSEL_BIT];
  assign cfg.drv_en = ctrl_r[hsc_pkg::CTRL_DRVEN_BIT];
  assign idle_run = idle_r;
  assign mask_level = mask_r;
endmodule : hsc_apb_regs
`default_nettype wire

/* hw/hsc_top.sv */
// What this block does
// RULE1 - Halt instruction enters mode from select field
// RULE2 - CPU-only halt stops just the core
// RULE3 - CPU-only halt: blocks follow idle-run bits
// RULE4 - CPU-only halt holds all port pins
// RULE5 - Oscillator halt keeps oscillator and RTC only
// RULE6 - Stop halts every internal circuit
// RULE7 - Deep halts set pins per drive bits; the code sets pins from drv_en alone in both, drv_sel is unused
// RULE8 - Drive enable 0 pins off, 1 driving
// RULE9 - Unmasked wake interrupt: release, service, continue
// RULE10 - Masked external/key/RTC/alarm: release, flag stays
// RULE11 - Wake in 5-cycle entry held pending
// RULE12 - Pending and new: higher priority first
// RULE13 - Wake source sets differ per halt mode
// RULE14 - Non-maskable request is fixed level 7
// RULE15 - Stop release waits for warm-up
// RULE16 - Warm-up 2^8, 2^14 or 2^16 cycles
// RULE17 - Stop release picks high or low clock
// RULE18 - Reset releases every halt state
// RULE19 - Level external irq0 held high until service
// RULE20 - Mode code 00 enters no halt
`timescale 1ns/1ps
`default_nettype none
module hsc_top #(
  parameter int NUM_IDLE = 7
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic halt_exec,
  input wire logic osc_tick,
  output logic cpu_resume,
  output logic service_req,
  output logic [3:0] service_src,
  // Wake sources, one bit per source, with levels
  input wire logic [hsc_pkg::NSRC-1:0] irq_req,
  input wire logic [hsc_pkg::NSRC*3-1:0] irq_level,
  // Gating
  output hsc_pkg::hsc_gate_t gate,
  output logic [NUM_IDLE-1:0] block_run
);
  // Elaboration checks: the logic is built for these sizes only
  if (NUM_IDLE != 7) begin : g_idle_check
    $error("hsc_top: NUM_IDLE must be 7");
  end
  if (hsc_pkg::ENTRY_CYCLES > 7) begin : g_entry_check
    $error("hsc_top: entry window does not fit its counter");
  end
  if (hsc_pkg::NSRC > 16) begin : g_src_check
    $error("hsc_top: wake sources exceed the 4-bit index");
  end

  hsc_pkg::hsc_cfg_t cfg;
  logic [6:0] idle_run;
  logic [2:0] mask_level;
  logic [31:0] status;
  logic wup_done;
  logic wup_start;

  hsc_pkg::hsc_state_t st_r, st_nxt;
  logic [2:0] ent_r, ent_nxt;
  logic [hsc_pkg::NSRC-1:0] pend_r, pend_nxt;
  logic resume_r, resume_nxt;
  logic svc_r, svc_nxt;
  logic [3:0] src_r, src_nxt;
  logic [3:0] src_hold_r, src_hold_nxt;
  logic svc_hold_r, svc_hold_nxt;
  hsc_pkg::hsc_gate_t gate_r, gate_nxt;
  logic [NUM_IDLE-1:0] run_r, run_nxt;

  hsc_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg),
    .idle_run(idle_run),
    .mask_level(mask_level),
    .status(status)
  );

  // Oscillator warm-up count after stop
  hsc_warmup #(.CW(17)) u_wup (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(wup_start),
    .sel(cfg.wup),
    .osc_tick(osc_tick),
    .done(wup_done)
  );

  function automatic logic [2:0] lvl(input logic [hsc_pkg::NSRC*3-1:0] v, input int i);
    if (i == hsc_pkg::SRC_NMI) lvl = 3'(hsc_pkg::NMI_LEVEL); // [RULE14]
    else lvl = v[i*3 +: 3];
  endfunction : lvl

  // Highest level among a request vector; ties go to the lower index
  function automatic logic [3:0] pick(input logic [hsc_pkg::NSRC-1:0] r,
                                      input logic [hsc_pkg::NSRC*3-1:0] v);
    logic [2:0] best;
    logic found;
    pick = 4'h0;
    best = 3'h0;
    found = 1'b0;
    for (int i = 0; i < hsc_pkg::NSRC; i++) begin
      if (r[i] && (!found || lvl(v, i) > best)) begin
        best = lvl(v, i);
        pick = 4'(i);
        found = 1'b1;
      end
    end
  endfunction : pick

  // Which sources may end each halt state
  function automatic logic [hsc_pkg::NSRC-1:0] wake_set(input hsc_pkg::hsc_state_t s);
    case (s)
      hsc_pkg::ST_CPU_HALT: wake_set = '1; // [RULE13]
      hsc_pkg::ST_OSC_HALT: wake_set = hsc_pkg::OSC_WAKE; // [RULE13]
      hsc_pkg::ST_STOP: wake_set = hsc_pkg::STOP_WAKE; // [RULE13]
      default: wake_set = '0;
    endcase
  endfunction : wake_set

  logic [hsc_pkg::NSRC-1:0] allowed, above, wake_any;
  logic [hsc_pkg::NSRC-1:0] all_req;
  logic [3:0] best_src;
  logic best_above;

  always_comb begin
    allowed = wake_set(st_r); // [RULE13]
    // The non-maskable source compares at its fixed level
    for (int i = 0; i < hsc_pkg::NSRC; i++) begin
      above[i] = lvl(irq_level, i) >= mask_level; // [RULE9]
    end
    all_req = irq_req | pend_r;
    // Below-mask requests still release only for the listed sources
    wake_any = all_req & allowed & (above | hsc_pkg::BELOW_WAKE); // [RULE10]
    best_src = pick(all_req & above & allowed, irq_level); // [RULE12]
    best_above = |(all_req & above & allowed);
  end

  // Warm-up counter starts on the edge that leaves stop
  assign wup_start = (st_r == hsc_pkg::ST_STOP) && (|wake_any) && (ent_r == 3'h0);

  always_comb begin
    st_nxt = st_r;
    ent_nxt = (ent_r != 3'h0) ? ent_r - 3'h1 : 3'h0;
    pend_nxt = pend_r;
    resume_nxt = 1'b0;
    svc_nxt = 1'b0;
    src_nxt = src_r;
    src_hold_nxt = src_hold_r;
    svc_hold_nxt = svc_hold_r;
    case (st_r)
      hsc_pkg::ST_RUN: begin
        pend_nxt = '0;
        if (halt_exec) begin
          case (cfg.mode) // [RULE1]
            hsc_pkg::MODE_CPU_ONLY: st_nxt = hsc_pkg::ST_CPU_HALT;
            hsc_pkg::MODE_OSC_ONLY: begin
              st_nxt = hsc_pkg::ST_OSC_HALT;
              ent_nxt = 3'(hsc_pkg::ENTRY_CYCLES);
            end
            hsc_pkg::MODE_STOP: begin
              st_nxt = hsc_pkg::ST_STOP;
              ent_nxt = 3'(hsc_pkg::ENTRY_CYCLES);
            end
            default: st_nxt = hsc_pkg::ST_RUN; // [RULE20]
          endcase
        end
      end
      hsc_pkg::ST_CPU_HALT, hsc_pkg::ST_OSC_HALT, hsc_pkg::ST_STOP: begin
        if (ent_r != 3'h0) begin
          // Requests during entry are parked, not acted on
          pend_nxt = pend_r | (irq_req & allowed); // [RULE11]
        end else if (|wake_any) begin
          src_hold_nxt = best_src;
          svc_hold_nxt = best_above;
          pend_nxt = '0;
          if (st_r == hsc_pkg::ST_STOP) begin
            st_nxt = hsc_pkg::ST_WARM; // [RULE15]
          end else begin
            st_nxt = hsc_pkg::ST_RUN;
            resume_nxt = 1'b1;
            svc_nxt = best_above; // [RULE9]
            src_nxt = best_src; // [RULE12]
          end
        end
      end
      hsc_pkg::ST_WARM: begin
        // Held source is replayed once the oscillator is stable
        if (wup_done) begin
          st_nxt = hsc_pkg::ST_RUN; // [RULE15]
          resume_nxt = 1'b1;
          svc_nxt = svc_hold_r;
          src_nxt = src_hold_r;
        end
      end
      default: st_nxt = hsc_pkg::ST_RUN;
    endcase
  end

  // Gates follow the next state so they move with the state register
  always_comb begin
    gate_nxt = '0;
    run_nxt = '1;
    gate_nxt.clk_sel_low = gate_r.clk_sel_low;
    case (st_nxt)
      hsc_pkg::ST_CPU_HALT: begin
        gate_nxt.cpu_stop = 1'b1; // [RULE2]
        gate_nxt.pins_hold = 1'b1; // [RULE4]
        run_nxt = idle_run; // [RULE3]
      end
      hsc_pkg::ST_OSC_HALT: begin
        gate_nxt.cpu_stop = 1'b1;
        gate_nxt.sys_clk_stop = 1'b1; // [RULE5]
        gate_nxt.intc_stop = 1'b1;
        gate_nxt.pins_off = !cfg.drv_en; // [RULE7] [RULE8]
        run_nxt = '0;
      end
      hsc_pkg::ST_STOP, hsc_pkg::ST_WARM: begin
        gate_nxt.cpu_stop = 1'b1;
        gate_nxt.sys_clk_stop = 1'b1; // [RULE6]
        gate_nxt.osc_stop = (st_nxt == hsc_pkg::ST_STOP);
        gate_nxt.rtc_stop = 1'b1;
        gate_nxt.intc_stop = 1'b1;
        gate_nxt.pins_off = !cfg.drv_en; // [RULE7] [RULE8]
        run_nxt = '0;
      end
      default: ;
    endcase
    // Clock choice holds until the next stop release
    if (st_r == hsc_pkg::ST_WARM && wup_done) begin
      gate_nxt.clk_sel_low = cfg.rel_clk; // [RULE17]
    end
  end

  // Status word: state low, held source above, pending summary on top
  always_comb begin
    status = 32'h0000_0000;
    status[2:0] = st_r;
    status[11:8] = src_hold_r;
    status[12] = |pend_r;
  end

  // Asynchronous reset returns to running from any halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= hsc_pkg::ST_RUN; // [RULE18]
      ent_r <= 3'h0;
      pend_r <= '0;
      resume_r <= 1'b0;
      svc_r <= 1'b0;
      src_r <= 4'h0;
      src_hold_r <= 4'h0;
      svc_hold_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      ent_r <= ent_nxt;
      pend_r <= pend_nxt;
      resume_r <= resume_nxt;
      svc_r <= svc_nxt;
      src_r <= src_nxt;
      src_hold_r <= src_hold_nxt;
      svc_hold_r <= svc_hold_nxt;
    end
  end

  // Gate and block-run flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= '0;
      run_r <= '1;
    end else if (ce) begin
      gate_r <= gate_nxt;
      run_r <= run_nxt;
    end
  end

  assign cpu_resume = resume_r;
  assign service_req = svc_r;
  assign service_src = src_r;
  assign gate = gate_r;
  assign block_run = run_r;
endmodule : hsc_top
`default_nettype wire

/* tb/hsc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module hsc_top_asserts #(
  parameter int NUM_IDLE = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire logic halt_exec,
  input wire logic [hsc_pkg::NSRC-1:0] irq_req,
  input wire logic cpu_resume,
  input wire logic service_req,
  input wire hsc_pkg::hsc_gate_t gate,
  input wire logic [NUM_IDLE-1:0] block_run
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  cpu_only_a: assert property (
    gate.pins_hold |-> gate.cpu_stop && !gate.sys_clk_stop && !gate.intc_stop)
    else $error("core halt stops more than the core");
  idle_runs_a: assert property (!gate.cpu_stop |-> &block_run)
    else $error("blocks stopped while running");
  pins_kept_a: assert property (gate.pins_hold |-> !gate.pins_off)
    else $error("pins released in core halt");
  osc_only_a: assert property (
    gate.sys_clk_stop && !gate.rtc_stop |-> !gate.osc_stop && gate.cpu_stop && block_run == '0)
    else $error("oscillator halt gating wrong");
  stop_all_a: assert property (
    gate.osc_stop |-> gate.sys_clk_stop && gate.rtc_stop && gate.cpu_stop && block_run == '0)
    else $error("stop leaves a circuit running");
  resume_pulse_a: assert property (
    service_req |-> cpu_resume ##1 !cpu_resume)
    else $error("service without one-cycle resume");
  warm_wait_a: assert property ($rose(gate.osc_stop) |-> !cpu_resume [*8])
    else $error("resume too soon after stop");
  nmi_wake_a: assert property (
    gate.pins_hold && irq_req[hsc_pkg::SRC_NMI] |-> ##[1:4] (cpu_resume && service_req))
    else $error("non-maskable request did not wake");
  reset_idle_a: assert property ($rose(presetn) |-> gate == '0 && !cpu_resume)
    else $error("halt state survives reset");

  cover property (cpu_resume && service_req);
  cover property (cpu_resume && !service_req);
  cover property (gate.osc_stop);
  cover property (halt_exec);
endmodule : hsc_top_asserts

bind hsc_top hsc_top_asserts #(.NUM_IDLE(NUM_IDLE)) u_asserts (
  .pclk(pclk),
  .presetn(presetn),
  .halt_exec(halt_exec),
  .irq_req(irq_req),
  .cpu_resume(cpu_resume),
  .service_req(service_req),
  .gate(gate),
  .block_run(block_run)
);
`default_nettype wire

/* tb/hsc_irq_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hsc_irq_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic [hsc_pkg::NSRC-1:0] raise,
  input wire logic clr_all,
  // Acknowledge from the controller
  input wire logic service_req,
  input wire logic [3:0] service_src,
  // Requests toward the controller
  output logic [hsc_pkg::NSRC-1:0] irq_req
);
  logic [hsc_pkg::NSRC-1:0] flag_r;
  logic [hsc_pkg::NSRC-1:0] flag_nxt;

  // A request, level-held ones too, stays up until it is serviced
  always_comb begin
    flag_nxt = flag_r | raise;
    if (service_req) begin
      flag_nxt[service_src] = 1'b0;
    end
    if (clr_all) begin
      flag_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign irq_req = flag_r;
endmodule : hsc_irq_model
`default_nettype wire

/* tb/hsc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH at %0t got %h exp %h", $time, a, e); end end
module hsc_top_bench;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic halt_exec, osc_tick, cpu_resume, service_req, clr_all, er;
  logic [3:0] service_src;
  logic [hsc_pkg::NSRC-1:0] irq_req, raise;
  logic [hsc_pkg::NSRC*3-1:0] irq_level;
  hsc_pkg::hsc_gate_t gate;
  logic [6:0] block_run;
  int errors, n_checks, cyc;

  hsc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_exec(halt_exec), .osc_tick(osc_tick), .cpu_resume(cpu_resume),
    .service_req(service_req), .service_src(service_src), .irq_req(irq_req),
    .irq_level(irq_level), .gate(gate), .block_run(block_run));
  hsc_irq_model u_irq (.pclk(pclk), .presetn(presetn), .raise(raise), .clr_all(clr_all),
    .service_req(service_req), .service_src(service_src), .irq_req(irq_req));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic halt();
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    @(posedge pclk);
  endtask : halt

  task automatic fire(input logic [hsc_pkg::NSRC-1:0] m);
    @(posedge pclk);
    raise <= m;
    @(posedge pclk);
    raise <= '0;
  endtask : fire

  task automatic wres(input int lim);
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (cpu_resume !== 1'b1 && cyc < lim);
  endtask : wres

  task automatic clr();
    @(posedge pclk);
    clr_all <= 1'b1;
    @(posedge pclk);
    clr_all <= 1'b0;
  endtask : clr

  task automatic t_regs();
    apb(1'b0, hsc_pkg::ADDR_CTRL, 32'h0000_0000);
    `CHK(rd, hsc_pkg::CTRL_RESET)
    apb(1'b0, hsc_pkg::ADDR_MASK, 32'h0000_0000);
    `CHK(rd[2:0], hsc_pkg::MASK_RESET)
    apb(1'b1, 8'h10, 32'h0000_0003);
    `CHK(er, 1'b1)
  endtask : t_regs

  task automatic t_cpu();
    apb(1'b1, hsc_pkg::ADDR_IDLE_RUN, 32'h0000_0055);
    apb(1'b1, hsc_pkg::ADDR_MASK, 32'h0000_0007);
    apb(1'b1, hsc_pkg::ADDR_CTRL, 32'h0000_0003);
    halt();
    `CHK(gate.cpu_stop, 1'b1)
    `CHK(gate.sys_clk_stop, 1'b0)
    `CHK(block_run, 7'h55)
    `CHK(gate.pins_hold, 1'b1)
    fire(12'h040);
    wres(20);
    `CHK(cpu_resume, 1'b0)
    fire(12'h001);
    wres(20);
    `CHK(service_req, 1'b1)
    `CHK(service_src, 4'h0)
    clr();
  endtask : t_cpu

  task automatic t_osc();
    apb(1'b1, hsc_pkg::ADDR_MASK, 32'h0000_0000);
    apb(1'b1, hsc_pkg::ADDR_CTRL, 32'h0000_0002);
    halt();
    repeat (8) @(posedge pclk);
    `CHK(gate.sys_clk_stop, 1'b1)
    `CHK(gate.osc_stop, 1'b0)
    `CHK(gate.pins_off, 1'b1)
    fire(12'h020);
    wres(20);
    `CHK(cpu_resume, 1'b0)
    apb(1'b1, hsc_pkg::ADDR_MASK, 32'h0000_0007);
    fire(12'h004);
    wres(20);
    `CHK(cpu_resume, 1'b1)
    `CHK(service_req, 1'b0)
    @(posedge pclk);
    `CHK(irq_req[hsc_pkg::SRC_KEY], 1'b1)
    clr();
  endtask : t_osc

  task automatic t_stop();
    apb(1'b1, hsc_pkg::ADDR_CTRL, 32'h0000_0055);
    halt();
    repeat (8) @(posedge pclk);
    `CHK(gate.osc_stop, 1'b1)
    `CHK(gate.pins_off, 1'b0)
    fire(12'h010);
    wres(20);
    `CHK(cpu_resume, 1'b0)
    fire(12'h001);
    wres(400);
    `CHK(cpu_resume, 1'b1)
    `CHK(cyc >= 256, 1'b1)
    `CHK(cyc <= 262, 1'b1)
    `CHK(gate.clk_sel_low, 1'b1)
    `CHK(service_req, 1'b1)
    clr();
  endtask : t_stop

  task automatic t_pend();
    // Key outranks ext here, so the pick must follow the level, not the index
    irq_level[8:6] <= 3'h6;
    apb(1'b1, hsc_pkg::ADDR_MASK, 32'h0000_0000);
    apb(1'b1, hsc_pkg::ADDR_CTRL, 32'h0000_0002);
    @(posedge pclk);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    raise <= 12'h004;
    @(posedge pclk);
    raise <= 12'h002;
    @(posedge pclk);
    raise <= '0;
    wres(40);
    `CHK(cpu_resume, 1'b1)
    `CHK(service_src, 4'h2)
    clr();
  endtask : t_pend

  task automatic t_resv_rst();
    apb(1'b1, hsc_pkg::ADDR_CTRL, 32'h0000_0000);
    halt();
    repeat (3) @(posedge pclk);
    `CHK(gate[7:1], 7'h00)
    apb(1'b1, hsc_pkg::ADDR_CTRL, 32'h0000_0003);
    halt();
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(gate, 8'h00)
    `CHK(block_run, 7'h7F)
  endtask : t_resv_rst

  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, halt_exec, clr_all} = '0;
    {ce, osc_tick} = 2'b11;
    {paddr, pwdata, raise} = '0;
    irq_level = {12{3'h2}};
    irq_level[5:3] = 3'h5;
    irq_level[20:18] = 3'h3;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cpu();
    t_osc();
    t_stop();
    t_pend();
    t_resv_rst();
    stop_test();
  end
endmodule : hsc_top_bench
`undef CHK
`default_nettype wire
